// ---- stop_core_side.sv ----
/*
 core/interrupt side end: apb registers drive the link, acks held requests.
 assumes an apb master on the system clock; no wait beyond one access cycle.
*/
`timescale 1ns/1ps
module stop_core_side
	import stop_pkg::*;
(
	input  wire logic        SYS_CLK,     // system clock
	input  wire logic        RST_N,       // async reset, active low
	input  wire logic        PSEL,        // apb select
	input  wire logic        PENABLE,     // apb access phase
	input  wire logic        PWRITE,      // apb direction
	input  wire logic [7:0]  PADDR,       // apb byte address
	input  wire logic [31:0] PWDATA,      // apb write data
	output logic [31:0]      PRDATA,      // apb read data
	output logic             PREADY,      // apb ready
	output logic             PSLVERR,     // apb error on unmapped
	output logic             ADC_CONV_EN, // adc conversion enable
	stop_link_if.cpu_mp      LINK         // standby controller link
);
	logic [11:0] ctrl_reg;
	logic [6:0]  svc_reg;
	logic        standby_control_reg_wr_reg;
	logic [7:0]  standby_control_reg_data_reg;
	logic [1:0]  nop_reg;
	logic        ack_nmi_reg, ack_ext_reg;
	logic [1:0]  outcome_reg, src_reg;
	logic        setup, wr_ok;

	// address match, used by both paths
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == CTRL_OFS) || (a == SVC_OFS) || (a == CMD_OFS) || (a == STAT_OFS);
	endfunction

	assign setup = PSEL & ~PENABLE;
	assign wr_ok = PSEL & PENABLE & PREADY & PWRITE & mapped(PADDR);

	// apb answer: ready in the first access cycle
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= '0;
		end else begin
			PREADY <= setup;
			PSLVERR <= setup & ~mapped(PADDR);
			PRDATA <= '0;
			if (setup && !PWRITE) begin
				if (PADDR == CTRL_OFS) begin
					PRDATA <= {20'h00000, ctrl_reg};
				end else if (PADDR == SVC_OFS) begin
					PRDATA <= {25'h0000000, svc_reg};
				end else if (PADDR == STAT_OFS) begin
					PRDATA <= {24'h000000, nop_reg, LINK.pend_ext, LINK.pend_nmi, src_reg, outcome_reg};
				end else if (PADDR == CMD_OFS) begin
					PRDATA <= {23'h000000, LINK.stop_active, standby_control_reg_data_reg};
				end
			end
		end
	end

	// control and service registers; stop command issues the dedicated write
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_reg <= '0;
			svc_reg <= '0;
			standby_control_reg_wr_reg <= 1'b0;
			standby_control_reg_data_reg <= STANDBY_CONTROL_REG_RESET;
		end else begin
			standby_control_reg_wr_reg <= 1'b0;
			if (wr_ok && PADDR == CTRL_OFS) begin
				ctrl_reg <= PWDATA[11:0];
			end else if (wr_ok && PADDR == SVC_OFS) begin
				svc_reg <= PWDATA[6:0];
			end else if (wr_ok && PADDR == CMD_OFS) begin
				standby_control_reg_wr_reg <= 1'b1;
				standby_control_reg_data_reg <= PWDATA[7:0];
				if (PWDATA[STOP_BIT]) begin
					ctrl_reg[C_ADC_EN] <= 1'b0;
				end
			end
		end
	end

	// three slots after each wake before a held request is taken
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			nop_reg <= '0;
			outcome_reg <= OUT_NONE;
			src_reg <= SRC_NONE;
		end else if (LINK.wake_done) begin
			nop_reg <= 2'(NOP_SLOTS);
			outcome_reg <= LINK.outcome;
			src_reg <= LINK.wake_src;
		end else if (nop_reg != 2'h0) begin
			nop_reg <= nop_reg - 2'h1;
		end
	end

	// take held requests once nothing blocks them
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ack_nmi_reg <= 1'b0;
			ack_ext_reg <= 1'b0;
		end else begin
			ack_nmi_reg <= LINK.pend_nmi & ~ack_nmi_reg & (nop_reg == 2'h0) & ~svc_reg[S_NMI_SVC] & ~svc_reg[S_NMI_HI];
			ack_ext_reg <= LINK.pend_ext & ~ack_ext_reg & (nop_reg == 2'h0) & ctrl_reg[C_IE] & ~svc_reg[S_IN_SVC];
		end
	end

	assign ADC_CONV_EN = ctrl_reg[C_ADC_EN];
	assign LINK.standby_control_reg_wr = standby_control_reg_wr_reg;
	assign LINK.standby_control_reg_dedicated = standby_control_reg_wr_reg;
	assign LINK.standby_control_reg_width8 = standby_control_reg_wr_reg;
	assign LINK.standby_control_reg_data = standby_control_reg_data_reg;
	assign LINK.wake_cond_pend = ctrl_reg[C_WAKE_PEND];
	assign LINK.ie = ctrl_reg[C_IE];
	assign LINK.priority_nesting_select = ctrl_reg[C_PRIORITY_NESTING_SELECT];
	assign LINK.mask_a = ctrl_reg[C_MASK_A];
	assign LINK.mask_b = ctrl_reg[C_MASK_B];
	assign LINK.macro_a = ctrl_reg[C_MACRO_A];
	assign LINK.macro_b = ctrl_reg[C_MACRO_B];
	assign LINK.ext_clock_select = ctrl_reg[C_EXT_CLK];
	assign LINK.settle_sel = ctrl_reg[C_SETTLE+:3];
	assign LINK.in_service = svc_reg[S_IN_SVC];
	assign LINK.svc_prio = svc_reg[S_SVC_PRIO+:2];
	assign LINK.ext_prio = svc_reg[S_EXT_PRIO+:2];
	assign LINK.nmi_in_svc = svc_reg[S_NMI_SVC];
	assign LINK.nmi_hi_in_svc = svc_reg[S_NMI_HI];
	assign LINK.pend_ack_nmi = ack_nmi_reg;
	assign LINK.pend_ack_ext = ack_ext_reg;
endmodule

// ---- stop_link_if.sv ----
/*
 link between the core/interrupt side and the standby controller.
 assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface stop_link_if;
	logic       standby_control_reg_wr;        // standby control write strobe
	logic       standby_control_reg_dedicated; // write came from the dedicated instruction
	logic       standby_control_reg_width8;    // write is an 8-bit immediate
	logic [7:0] standby_control_reg_data;
	logic       wake_cond_pend; // a halt release condition is pending
	logic       ie;             // interrupt_enable_flag
	logic       priority_nesting_select;           // priority_nesting_select
	logic       mask_a, mask_b;
	logic       macro_a, macro_b;
	logic       in_service;
	logic [1:0] svc_prio, ext_prio;
	logic       nmi_in_svc, nmi_hi_in_svc;
	logic       ext_clock_select;
	logic [2:0] settle_sel;
	logic       pend_ack_nmi, pend_ack_ext;
	logic       stop_active;
	logic       wake_done;
	logic [1:0] outcome, wake_src;
	logic       pend_nmi, pend_ext;
	modport dev_mp (input standby_control_reg_wr, standby_control_reg_dedicated, standby_control_reg_width8, standby_control_reg_data, wake_cond_pend, ie, priority_nesting_select,
		mask_a, mask_b, macro_a, macro_b, in_service, svc_prio, ext_prio, nmi_in_svc, nmi_hi_in_svc,
		ext_clock_select, settle_sel, pend_ack_nmi, pend_ack_ext,
		output stop_active, wake_done, outcome, wake_src, pend_nmi, pend_ext);
	modport cpu_mp (output standby_control_reg_wr, standby_control_reg_dedicated, standby_control_reg_width8, standby_control_reg_data, wake_cond_pend, ie, priority_nesting_select,
		mask_a, mask_b, macro_a, macro_b, in_service, svc_prio, ext_prio, nmi_in_svc, nmi_hi_in_svc,
		ext_clock_select, settle_sel, pend_ack_nmi, pend_ack_ext,
		input stop_active, wake_done, outcome, wake_src, pend_nmi, pend_ext);
endinterface

// ---- stop_pkg.sv ----
/*
 stop standby controller: shared constants, state and outcome types.
 assumes one 25 MHz system clock shared by both ends.
*/
package stop_pkg;
	localparam int CLK_MHZ = 25;
	// standby control byte: position of the stop request bit
	localparam int STOP_BIT = 1;
	// lowest maskable priority level (0 is highest)
	localparam logic [1:0] PRIO_LOWEST = 2'h3;
	// base oscillator settle time, scaled by 2**select
	localparam int SETTLE_BASE_US = 2;
	localparam int SETTLE_BASE_CYC = SETTLE_BASE_US * CLK_MHZ;
	localparam int CNT_W = 16;
	// instruction slots the core spends after a wake
	localparam int NOP_SLOTS = 3;
	// apb register offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] SVC_OFS = 8'h04;
	localparam logic [7:0] CMD_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0C;
	// ctrl fields
	localparam int C_IE = 0;
	localparam int C_PRIORITY_NESTING_SELECT = 1;
	localparam int C_MASK_A = 2;
	localparam int C_MASK_B = 3;
	localparam int C_MACRO_A = 4;
	localparam int C_MACRO_B = 5;
	localparam int C_WAKE_PEND = 6;
	localparam int C_EXT_CLK = 7;
	localparam int C_ADC_EN = 8;
	localparam int C_SETTLE = 9;
	// svc fields
	localparam int S_IN_SVC = 0;
	localparam int S_SVC_PRIO = 1;
	localparam int S_EXT_PRIO = 3;
	localparam int S_NMI_SVC = 5;
	localparam int S_NMI_HI = 6;
	localparam logic [7:0] STANDBY_CONTROL_REG_RESET = 8'h00;
	typedef enum logic [1:0] {
		ST_RUN    = 2'b00,
		ST_STOP   = 2'b01,
		ST_SETTLE = 2'b11,
		ST_DECIDE = 2'b10
	} state_t;
	typedef enum logic [1:0] {SRC_NONE = 2'h0, SRC_NMI = 2'h1, SRC_EXT = 2'h2} src_t;
	typedef enum logic [1:0] {OUT_NONE = 2'h0, OUT_VECTOR = 2'h1, OUT_RESUME = 2'h2, OUT_REFUSED = 2'h3} outcome_t;
endpackage

// ---- stop_standby_ctrl.sv ----
/*
 standby controller end: stop entry, pin freeze, wake and resume decision.
 assumes the core end drives the link on the same clock; pins synchronous.
*/
// Function
// - stop bit written one enters stop
// - only dedicated 8-bit writes reach control byte
// - pending wake condition refuses stop entry
// - core spends three slots after wake
// - stop halts oscillator, clock, core, peripherals
// - io lines hold, ram kept
// - converter runs; output floats when channel off
// - external clock needs select bit set
// - software clears adc enable before stop; here the stop command write clears it
// - wake only by nmi, pins a/b, reset
// - nmi in own routine: resume, hold pending
// - higher nmi running: resume, hold pending
// - pin wake needs mask and macro zero
// - blocked or ie zero: resume, pending
// - level 3 with nesting clear: acknowledge
// - pending requests acknowledged when possible
// - reset vectors normally, ram preserved
// - nmi wake restarts oscillator, waits settle time
// - reset out of stop keeps data memory
`timescale 1ns/1ps
module stop_standby_ctrl
	import stop_pkg::*;
#(
	parameter int GPIO_W = 8,
	parameter int DAC_N = 2
) (
	input  wire logic              SYS_CLK,            // system clock
	input  wire logic              RST_N,              // async reset, active low
	stop_link_if.dev_mp            LINK,               // core side link
	input  wire logic              NMI_PIN,            // non-maskable interrupt pin
	input  wire logic              NMI_EDGE_RISE,      // nmi valid edge: 1 rising
	input  wire logic              EXT_INT_PIN_A,      // external interrupt pin a
	input  wire logic              EXT_INT_PIN_B,      // external interrupt pin b
	input  wire logic              EXT_EDGE_RISE,      // pin a/b valid edge: 1 rising
	input  wire logic [GPIO_W-1:0] GPIO_D,             // core value for io lines
	input  wire logic              BUS_OE_REQ,         // core wants address/data bus
	input  wire logic              STROBE_OE_REQ,      // core drives strobes
	input  wire logic              REFRESH_D,          // core refresh request value
	input  wire logic              HOLD_REQUEST_IN,    // bus hold request
	input  wire logic [DAC_N-1:0]  DAC_CHANNEL_ENABLE, // converter channel enables
	output logic [GPIO_W-1:0]      GPIO_OUT,           // io line levels
	output logic                   OSC_RUN,            // oscillator running
	output logic                   SYS_CLK_EN,         // internal system clock enable
	output logic                   CPU_RUN,            // core may execute
	output logic                   PERIPH_RUN,         // peripherals run
	output logic                   RAM_WE_EN,          // internal ram write enable
	output logic                   BUS_OE,             // muxed_addr_data_bus enable
	output logic                   STROBE_OE,          // rd/wr and address_strobe_out enable
	output logic                   REFRESH_REQUEST_OUT,// refresh_request_out
	output logic                   HOLD_ACK_OUT,       // hold_ack_out
	output logic                   DAC_RUN,            // converter clocked
	output logic [DAC_N-1:0]       DAC_OE              // dac_output_pin enables
);
	state_t          state_reg, state_next;
	src_t            src_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic            nmi_q, a_q, b_q;
	logic            nmi_edge, a_edge, b_edge, ext_ok, stop_req;
	logic            wake_done_reg, pend_nmi_reg, pend_ext_reg;
	outcome_t        outcome_reg, decide;
	logic [7:0]      standby_control_reg_reg;

	// true when a running routine blocks the pin request
	function automatic logic ext_blocked(input logic in_svc, input logic [1:0] svc_p,
		input logic [1:0] req_p, input logic priority_nesting_select);
		logic lvl3_open;
		lvl3_open = ~priority_nesting_select && (svc_p == PRIO_LOWEST);
		ext_blocked = in_svc && (svc_p <= req_p) && !lvl3_open;
	endfunction

	// settle count from the select field
	function automatic logic [CNT_W-1:0] settle_cycles(input logic [2:0] sel, input logic ext_clk);
		logic [CNT_W-1:0] base;
		base = CNT_W'(SETTLE_BASE_CYC);
		settle_cycles = ext_clk ? CNT_W'(1) : (base << sel);
	endfunction

	// edge detection on the wake pins
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			nmi_q <= 1'b0;
			a_q <= 1'b0;
			b_q <= 1'b0;
		end else begin
			nmi_q <= NMI_PIN;
			a_q <= EXT_INT_PIN_A;
			b_q <= EXT_INT_PIN_B;
		end
	end

	assign nmi_edge = NMI_EDGE_RISE ? (NMI_PIN & ~nmi_q) : (~NMI_PIN & nmi_q);
	assign a_edge = EXT_EDGE_RISE ? (EXT_INT_PIN_A & ~a_q) : (~EXT_INT_PIN_A & a_q);
	assign b_edge = EXT_EDGE_RISE ? (EXT_INT_PIN_B & ~b_q) : (~EXT_INT_PIN_B & b_q);
	// pins wake only when unmasked with macro service off
	assign ext_ok = (a_edge & ~LINK.mask_a & ~LINK.macro_a) | (b_edge & ~LINK.mask_b & ~LINK.macro_b);
	// control byte accepts only dedicated 8-bit writes
	assign stop_req = LINK.standby_control_reg_wr & LINK.standby_control_reg_dedicated & LINK.standby_control_reg_width8 & LINK.standby_control_reg_data[STOP_BIT];

	// standby control byte image
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			standby_control_reg_reg <= STANDBY_CONTROL_REG_RESET;
		end else if (LINK.standby_control_reg_wr && LINK.standby_control_reg_dedicated && LINK.standby_control_reg_width8) begin
			standby_control_reg_reg <= LINK.standby_control_reg_data;
		end else if (state_reg == ST_DECIDE) begin
			standby_control_reg_reg[STOP_BIT] <= 1'b0;
		end
	end

	// resume decision for the wake source
	always_comb begin
		decide = OUT_VECTOR;
		if (src_reg == SRC_NMI) begin
			if (LINK.nmi_in_svc || LINK.nmi_hi_in_svc) begin
				decide = OUT_RESUME;
			end
		end else if (!LINK.ie || ext_blocked(LINK.in_service, LINK.svc_prio, LINK.ext_prio, LINK.priority_nesting_select)) begin
			decide = OUT_RESUME;
		end
	end

	// next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (stop_req && !LINK.wake_cond_pend) begin
					state_next = ST_STOP;
				end
			end
			ST_STOP: begin
				if (nmi_edge || ext_ok) begin
					state_next = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (cnt_reg <= CNT_W'(1)) begin
					state_next = ST_DECIDE;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	// state, source and settle counter; reset vectors normally, ram untouched
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= ST_RUN;
			src_reg <= SRC_NONE;
			cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			if (state_reg == ST_STOP && state_next == ST_SETTLE) begin
				src_reg <= nmi_edge ? SRC_NMI : SRC_EXT;
				cnt_reg <= settle_cycles(LINK.settle_sel, LINK.ext_clock_select);
			end else if (state_reg == ST_SETTLE) begin
				cnt_reg <= cnt_reg - CNT_W'(1);
			end
		end
	end

	// wake report to the core
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wake_done_reg <= 1'b0;
			outcome_reg <= OUT_NONE;
		end else begin
			wake_done_reg <= 1'b0;
			if (state_reg == ST_RUN && stop_req && LINK.wake_cond_pend) begin
				wake_done_reg <= 1'b1;
				outcome_reg <= OUT_REFUSED;
			end else if (state_reg == ST_DECIDE) begin
				wake_done_reg <= 1'b1;
				outcome_reg <= decide;
			end
		end
	end

	// held requests stay until the core takes them; a new hold wins over the ack
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pend_nmi_reg <= 1'b0;
			pend_ext_reg <= 1'b0;
		end else begin
			if (state_reg == ST_DECIDE && decide == OUT_RESUME && src_reg == SRC_NMI) begin
				pend_nmi_reg <= 1'b1;
			end else if (LINK.pend_ack_nmi) begin
				pend_nmi_reg <= 1'b0;
			end
			if (state_reg == ST_DECIDE && decide == OUT_RESUME && src_reg == SRC_EXT) begin
				pend_ext_reg <= 1'b1;
			end else if (LINK.pend_ack_ext) begin
				pend_ext_reg <= 1'b0;
			end
		end
	end

	assign LINK.stop_active = standby_control_reg_reg[STOP_BIT];
	assign LINK.wake_done = wake_done_reg;
	assign LINK.outcome = outcome_reg;
	assign LINK.wake_src = src_reg;
	assign LINK.pend_nmi = pend_nmi_reg;
	assign LINK.pend_ext = pend_ext_reg;

	// clock tree and run enables follow the next state
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			OSC_RUN <= 1'b1;
			SYS_CLK_EN <= 1'b1;
			CPU_RUN <= 1'b1;
			PERIPH_RUN <= 1'b1;
			RAM_WE_EN <= 1'b1;
		end else begin
			OSC_RUN <= (state_next != ST_STOP);
			SYS_CLK_EN <= (state_next == ST_RUN);
			CPU_RUN <= (state_next == ST_RUN);
			PERIPH_RUN <= (state_next == ST_RUN);
			RAM_WE_EN <= (state_next == ST_RUN);
		end
	end

	// pins: io frozen, bus floats, refresh kept, hold ack low while halted
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			GPIO_OUT <= '0;
			BUS_OE <= 1'b0;
			STROBE_OE <= 1'b0;
			REFRESH_REQUEST_OUT <= 1'b0;
			HOLD_ACK_OUT <= 1'b0;
		end else if (state_next != ST_RUN) begin
			BUS_OE <= 1'b0;
			STROBE_OE <= 1'b0;
			HOLD_ACK_OUT <= 1'b0;
		end else begin
			GPIO_OUT <= GPIO_D;
			BUS_OE <= BUS_OE_REQ;
			STROBE_OE <= STROBE_OE_REQ;
			REFRESH_REQUEST_OUT <= REFRESH_D;
			HOLD_ACK_OUT <= HOLD_REQUEST_IN;
		end
	end

	// converter ignores standby; output floats only when its channel is off
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			DAC_RUN <= 1'b0;
			DAC_OE <= '0;
		end else begin
			DAC_RUN <= |DAC_CHANNEL_ENABLE;
			DAC_OE <= DAC_CHANNEL_ENABLE;
		end
	end
endmodule

// ---- stop_sva.sv ----
/*
 checker for the standby link: stop entry, refusal, wake outcome, pending requests.
 assumes it sits beside the link interface and shares its clock and reset.
*/
`timescale 1ns/1ps
module stop_sva
	import stop_pkg::*;
(
	input wire logic       SYS_CLK,        // clock
	input wire logic       RST_N,          // reset, active low
	input wire logic       standby_control_reg_wr,        // write strobe
	input wire logic       standby_control_reg_dedicated, // dedicated write
	input wire logic       standby_control_reg_width8,    // byte write
	input wire logic [7:0] standby_control_reg_data,      // control byte
	input wire logic       wake_cond_pend, // wake pending
	input wire logic       ie,             // interrupt enable
	input wire logic       priority_nesting_select,           // nesting select
	input wire logic       in_service,     // routine running
	input wire logic [1:0] svc_prio,       // running level
	input wire logic [1:0] ext_prio,       // pin level
	input wire logic       nmi_in_svc,     // nmi routine
	input wire logic       nmi_hi_in_svc,  // higher nmi routine
	input wire logic       pend_ack_nmi,   // nmi ack
	input wire logic       pend_ack_ext,   // pin ack
	input wire logic       stop_active,    // stop bit image
	input wire logic       wake_done,      // wake pulse
	input wire logic [1:0] outcome,        // wake outcome
	input wire logic [1:0] wake_src,       // wake source
	input wire logic       pend_nmi,       // nmi held
	input wire logic       pend_ext        // pin held
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	logic ext_blk;
	// pin request blocked by a running routine of same or higher level
	assign ext_blk = in_service && svc_prio <= ext_prio && !(!priority_nesting_select && svc_prio == PRIO_LOWEST);
	sequence s_go;
		standby_control_reg_wr && standby_control_reg_dedicated && standby_control_reg_width8 && standby_control_reg_data[STOP_BIT] && !wake_cond_pend;
	endsequence
	sequence s_refuse;
		standby_control_reg_wr && standby_control_reg_dedicated && standby_control_reg_width8 && standby_control_reg_data[STOP_BIT] && wake_cond_pend;
	endsequence
	property p_enter; s_go |=> stop_active; endproperty
	property p_refuse; s_refuse |=> wake_done && outcome == OUT_REFUSED; endproperty
	property p_core_ded; standby_control_reg_wr |-> standby_control_reg_dedicated && standby_control_reg_width8 ##1 !standby_control_reg_wr; endproperty
	property p_nmi_out;
		wake_done && wake_src == SRC_NMI |-> outcome == ((nmi_in_svc || nmi_hi_in_svc) ? OUT_RESUME : OUT_VECTOR);
	endproperty
	property p_ext_out;
		wake_done && wake_src == SRC_EXT |-> outcome == ((!ie || ext_blk) ? OUT_RESUME : OUT_VECTOR);
	endproperty
	property p_hold;
		wake_done && outcome == OUT_RESUME |-> (wake_src == SRC_NMI ? pend_nmi : pend_ext);
	endproperty
	property p_ack_nmi; pend_ack_nmi |-> pend_nmi && !nmi_in_svc && !nmi_hi_in_svc ##1 !pend_nmi; endproperty
	property p_ack_ext; pend_ack_ext |-> pend_ext && ie && !in_service ##1 !pend_ext; endproperty
	property p_keep; pend_nmi && !pend_ack_nmi |=> pend_nmi; endproperty
	a_enter:    assert property (p_enter) else $error("stop not entered");
	a_refuse:   assert property (p_refuse) else $error("pending wake did not refuse stop");
	a_core_ded: assert property (p_core_ded) else $error("control write not a dedicated byte pulse");
	a_nmi_out:  assert property (p_nmi_out) else $error("wrong nmi wake outcome");
	a_ext_out:  assert property (p_ext_out) else $error("wrong pin wake outcome");
	a_hold:     assert property (p_hold) else $error("resumed request not held");
	a_ack_nmi:  assert property (p_ack_nmi) else $error("bad nmi ack");
	a_ack_ext:  assert property (p_ack_ext) else $error("bad pin ack");
	a_keep:     assert property (p_keep) else $error("held nmi lost without ack");
endmodule

// ---- testbench.sv ----
/*
 testbench: both controller ends on one link, apb stimulus, pin wakes, model compare.
 assumes the package constants and one 25 MHz clock.
*/
`timescale 1ns/1ps
module testbench
	import stop_pkg::*;
;
	logic        clk, rst_n, psel, pen, pwr, pready, pslverr, adc, erv;
	logic [7:0]  paddr, gpio_d, gpio_out;
	logic [31:0] pwdata, prdata, rdv;
	logic        nmi, pa, pb, bus_req, stb_req, ref_d, hold_rq, edge_rise;
	logic [1:0]  dac_en, dac_oe;
	logic        osc, clken, cpu, per, ramwe, bus_oe, stb_oe, ref_o, hack, dac_run;
	logic [15:0] lf;
	int          miscompares, samples_checked, ie, priority_nesting_select, insv, sp, ep, nm, nh;
	// src sel xc ie priority_nesting_select insv sp ep nm nh packed high to low
	localparam logic [13:0] CASES [11] = '{14'h1180, 14'h1582, 14'h1981, 14'h1383, 14'h2180, 14'h21F4,
		14'h21D4, 14'h217C, 14'h21FC, 14'h2480, 14'h21C8};
	stop_link_if stop_link_if_i ();
	stop_standby_ctrl stop_standby_ctrl_i (.SYS_CLK(clk), .RST_N(rst_n), .LINK(stop_link_if_i), .NMI_PIN(nmi),
		.NMI_EDGE_RISE(edge_rise), .EXT_INT_PIN_A(pa), .EXT_INT_PIN_B(pb), .EXT_EDGE_RISE(edge_rise), .GPIO_D(gpio_d),
		.BUS_OE_REQ(bus_req), .STROBE_OE_REQ(stb_req), .REFRESH_D(ref_d), .HOLD_REQUEST_IN(hold_rq),
		.DAC_CHANNEL_ENABLE(dac_en), .GPIO_OUT(gpio_out), .OSC_RUN(osc), .SYS_CLK_EN(clken), .CPU_RUN(cpu),
		.PERIPH_RUN(per), .RAM_WE_EN(ramwe), .BUS_OE(bus_oe), .STROBE_OE(stb_oe), .REFRESH_REQUEST_OUT(ref_o),
		.HOLD_ACK_OUT(hack), .DAC_RUN(dac_run), .DAC_OE(dac_oe));
	stop_core_side stop_core_side_i (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.ADC_CONV_EN(adc), .LINK(stop_link_if_i));
	stop_sva stop_sva_i (.SYS_CLK(clk), .RST_N(rst_n), .standby_control_reg_wr(stop_link_if_i.standby_control_reg_wr),
		.standby_control_reg_dedicated(stop_link_if_i.standby_control_reg_dedicated), .standby_control_reg_width8(stop_link_if_i.standby_control_reg_width8),
		.standby_control_reg_data(stop_link_if_i.standby_control_reg_data), .wake_cond_pend(stop_link_if_i.wake_cond_pend),
		.ie(stop_link_if_i.ie), .priority_nesting_select(stop_link_if_i.priority_nesting_select), .in_service(stop_link_if_i.in_service),
		.svc_prio(stop_link_if_i.svc_prio), .ext_prio(stop_link_if_i.ext_prio),
		.nmi_in_svc(stop_link_if_i.nmi_in_svc), .nmi_hi_in_svc(stop_link_if_i.nmi_hi_in_svc),
		.pend_ack_nmi(stop_link_if_i.pend_ack_nmi), .pend_ack_ext(stop_link_if_i.pend_ack_ext),
		.stop_active(stop_link_if_i.stop_active), .wake_done(stop_link_if_i.wake_done),
		.outcome(stop_link_if_i.outcome), .wake_src(stop_link_if_i.wake_src),
		.pend_nmi(stop_link_if_i.pend_nmi), .pend_ext(stop_link_if_i.pend_ext));
	// free running system clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// pseudo random source
	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic stop_test;
		$display("checked=%0d miscompares=%0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chkp(input logic [15:0] g, input logic [15:0] e);
		chk(32'(g), 32'(e));
	endtask
	// one apb transfer, waits for pready, leaves read data and error in rdv and erv
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// expected wake outcome: 1 vector, 2 resume
	function automatic int exp_out(input int src);
		if (src == 1) return (nm | nh) ? 2 : 1;
		if (!ie || (insv && sp <= ep && !(!priority_nesting_select && sp == 3))) return 2;
		return 1;
	endfunction
	// enter stop, check frozen pins, try blocked pins, wake and check timing and outcome
	task automatic run_case(input int src, input int sel, input int xc);
		int n, o;
		logic [7:0] g;
		lf = nx(lf);
		g = lf[7:0];
		apb(1'b1, CTRL_OFS, 32'(ie | priority_nesting_select << 1 | (src == 1 ? 32'hC : 32'h20) | xc << 7 | 32'h100 | sel << 9));
		apb(1'b1, SVC_OFS, 32'(insv | sp << 1 | ep << 3 | nm << 5 | nh << 6));
		gpio_d <= g;
		ref_d <= lf[8];
		dac_en <= lf[10:9];
		stb_req <= lf[11];
		bus_req <= 1'b1;
		hold_rq <= 1'b1;
		repeat (3) @(posedge clk);
		chkp({adc, gpio_out}, {1'b1, g});
		apb(1'b1, CMD_OFS, 32'h02);
		repeat (3) @(posedge clk);
		chkp({osc, clken, cpu, per, ramwe, bus_oe, stb_oe, hack}, 0);
		gpio_d <= ~g;
		ref_d <= ~lf[8];
		pa <= (src == 1);
		pb <= 1'b1;
		repeat (3) @(posedge clk);
		pa <= 1'b0;
		pb <= 1'b0;
		repeat (3) @(posedge clk);
		chkp({gpio_out, ref_o, cpu, adc, dac_run, dac_oe}, {g, lf[8], 2'b00, |lf[10:9], lf[10:9]});
		if (src == 1) nmi <= 1'b1;
		else pa <= 1'b1;
		n = 0;
		while (osc !== 1'b1 && n < 10) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		while (cpu !== 1'b1 && n < 9000) begin
			@(posedge clk);
			n++;
		end
		chk(32'(n), 32'((xc ? 1 : SETTLE_BASE_CYC << sel) + 1));
		nmi <= 1'b0;
		pa <= 1'b0;
		o = exp_out(src);
		apb(1'b0, STAT_OFS, 32'h0);
		chk(rdv & 32'h3F, 32'(o | src << 2 | (o == 2 ? 32'h8 << src : 32'h0)));
		chkp(gpio_out, {8'h00, ~g});
		apb(1'b1, SVC_OFS, 32'h0);
		apb(1'b1, CTRL_OFS, 32'h1);
		repeat (8) @(posedge clk);
		apb(1'b0, STAT_OFS, 32'h0);
		chk(rdv & 32'h30, 32'h0);
	endtask
	// main sequence
	initial begin
		logic [13:0] c;
		{psel, pen, pwr, paddr, pwdata, rst_n, erv, rdv} = '0;
		{nmi, pa, pb, bus_req, stb_req, ref_d, hold_rq, gpio_d, dac_en} = '0;
		edge_rise = 1'b1;
		miscompares = 0;
		samples_checked = 0;
		lf = 16'hCBF4;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, STAT_OFS, 32'h0);
		chk(rdv, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk({erv, rdv[30:0]}, 32'h80000000);
		apb(1'b1, CTRL_OFS, 32'h40);
		apb(1'b1, CMD_OFS, 32'h02);
		repeat (3) @(posedge clk);
		apb(1'b0, STAT_OFS, 32'h0);
		chk({cpu, rdv[30:0] & 31'h3}, 32'h80000003);
		apb(1'b1, CTRL_OFS, 32'h0);
		apb(1'b1, CMD_OFS, 32'hFD);
		repeat (3) @(posedge clk);
		chkp(cpu, 1);
		for (int i = 0; i < 11; i++) begin
			c = CASES[i];
			ie = c[8];
			priority_nesting_select = c[7];
			insv = c[6];
			sp = c[5:4];
			ep = c[3:2];
			nm = c[1];
			nh = c[0];
			run_case(c[13:12], c[11:10], c[9]);
		end
		// falling valid edge: nmi idles high, its fall wakes the controller
		edge_rise <= 1'b0;
		nmi <= 1'b1;
		apb(1'b1, CMD_OFS, 32'h02);
		repeat (3) @(posedge clk);
		chkp(cpu, 0);
		nmi <= 1'b0;
		repeat (SETTLE_BASE_CYC + 4) @(posedge clk);
		chkp(cpu, 1);
		apb(1'b1, CMD_OFS, 32'h02);
		repeat (3) @(posedge clk);
		chkp(cpu, 0);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chkp({cpu, ramwe, osc}, 3'h7);
		stop_test();
	end
	// watchdog for a hung wait
	initial begin
		#800000;
		miscompares++;
		stop_test();
	end
endmodule
